// ### shared/hep_defines.svh
// Constants of the hub endpoint and port command unit.
`ifndef HEP_DEFINES_SVH
`define HEP_DEFINES_SVH

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define HEP_CLK_MHZ 200
`define HEP_PRST_TIME_US 10000
`define HEP_PRST_CYCLES (`HEP_PRST_TIME_US * `HEP_CLK_MHZ)
`define HEP_TIMER_W 22

// ------------------------------------------------------------
// Link addresses, endpoints and command codes
// ------------------------------------------------------------
`define HEP_ADDR_CMD 7'h1b
`define HEP_ADDR_DATA 7'h1a
`define HEP_EP_NUM 14
`define HEP_CMD_SEL_LO 8'h00
`define HEP_CMD_SEL_HI 8'h0d
`define HEP_CMD_STALL_LO 8'h40
`define HEP_CMD_STALL_HI 8'h4d
`define HEP_CMD_CLR_P0 8'he0
`define HEP_CMD_CLR_P1 8'he1
`define HEP_CMD_SET_P0 8'he8
`define HEP_CMD_SET_P1 8'he9
`define HEP_CMD_ACK_SETUP 8'hf1
`define HEP_CMD_CLR_BUF 8'hf2
`define HEP_CMD_LOCAL_CHG 8'hf7
`define HEP_CMD_VALIDATE 8'hfa

// ------------------------------------------------------------
// Feature selectors and status bit positions
// ------------------------------------------------------------
`define HEP_FT_ENABLE 3'h0
`define HEP_FT_SUSPEND 3'h1
`define HEP_FT_RESTART 3'h2
`define HEP_FT_POWER 3'h3
`define HEP_FT_C_CONN 3'h4
`define HEP_FT_C_ENABLE 3'h5
`define HEP_FT_C_SUSPEND 3'h6
`define HEP_FT_C_OVERCUR 3'h7
`define HEP_ST_CONN 0
`define HEP_ST_ENABLE 1
`define HEP_ST_SUSPEND 2
`define HEP_ST_OVERCUR 3
`define HEP_ST_RESET 4
`define HEP_ST_POWER 5
`define HEP_ST_LOWSPEED 6

`endif

// ### shared/hep_if.sv
// Byte carrier between the serial link slave and the command core.
`timescale 1ns/10ps
`default_nettype none
interface hep_if;
    logic rx_valid;
    logic rx_cmd;
    logic [7:0] rx_byte;
    logic rd_req;
    logic [7:0] tx_byte;
    modport link (output rx_valid, output rx_cmd, output rx_byte, output rd_req,
        input tx_byte);
    modport core (input rx_valid, input rx_cmd, input rx_byte, input rd_req,
        output tx_byte);
endinterface : hep_if
`default_nettype wire

// ### shared/hep_pkg.sv
// Types of the hub endpoint and port command unit.
`include "hep_defines.svh"
package hep_pkg;
    typedef enum logic [2:0] {
        hep_idle = 3'h0,
        hep_addr = 3'h1,
        hep_aack = 3'h2,
        hep_rx = 3'h3,
        hep_dack = 3'h4,
        hep_tx = 3'h5,
        hep_mack = 3'h6
    } hep_link_state_t;

    typedef struct packed {
        logic scl1, scl2, scl3, sda1, sda2, sda3;
        hep_link_state_t state;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic rw, sel_cmd, sda_oe, rx_valid, rx_cmd, rd_req;
        logic [7:0] rx_byte;
    } hep_link_t;

    typedef struct packed {
        logic [1:0] con1, con2, ls1, ls2, oc1, oc2;
        logic mode1, mode2, sda_o;
        logic [7:0] cmd, tx_byte;
        logic wr_done;
        logic [1:0] rd_idx;
        logic [3:0] sel;
        logic [`HEP_EP_NUM-1:0] full, stall, tog, blk;
        logic [1:0] conn, ls, oc_st, en, susp, rst, c_conn, c_en, c_susp, c_rst;
        logic c_oc, power, oc_det;
        logic [1:0] local_chg;
        logic [3:0] hub_chg;
        logic [1:0][`HEP_TIMER_W-1:0] rtim;
    } hep_core_t;
endpackage : hep_pkg

// ### test/hep_master.sv
// Serial link master standing in for the system controller.
`timescale 1ns/10ps
`default_nettype none
module hep_master (
    input wire logic i_clk,
    input wire logic i_sda_oe,
    output logic o_scl,
    output logic o_sda
);
    logic drv = 1'b1;
    initial o_scl = 1'b1;
    // The data line is pulled up; either party may pull it low.
    assign o_sda = drv & i_sda_oe;
    // The link clock only moves inside these tasks; it rests high between frames.
    task automatic hp(input int n);
        repeat (n) @(posedge i_clk);
    endtask : hp
    task automatic bit_io(input logic b, output logic r);
        hp(4);
        drv <= b;
        hp(12);
        o_scl <= 1'b1;
        hp(16);
        r = o_sda;
        o_scl <= 1'b0;
    endtask : bit_io
    task automatic start();
        hp(4);
        drv <= 1'b1;
        hp(12);
        o_scl <= 1'b1;
        hp(16);
        drv <= 1'b0;
        hp(16);
        o_scl <= 1'b0;
    endtask : start
    task automatic stop();
        hp(4);
        drv <= 1'b0;
        hp(12);
        o_scl <= 1'b1;
        hp(16);
        drv <= 1'b1;
        hp(16);
    endtask : stop
    // Eight bits out MSB first, then the ninth bit; each bit seen on the line is sampled back into r and n.
    task automatic xfer(input logic [7:0] w, input logic a, output logic [7:0] r,
        output logic n);
        for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
        bit_io(a, n);
    endtask : xfer
endmodule : hep_master
`default_nettype wire

// ### test/tb_top.sv
// Command sequence bench for the hub endpoint and port command unit.
`timescale 1ns/10ps
`default_nettype none
`include "hep_defines.svh"
module tb_top;
    import hep_pkg::*;
    logic i_clk = 1'b0, i_reset = 1'b1, i_pkt_done = 1'b0, i_setup = 1'b0;
    logic [3:0] i_pkt_ep = 4'h0, i_setup_ep = 4'h0;
    logic mode = 1'b0;
    logic [1:0] oc = 2'h0;
    logic [13:0] full, stall, tog;
    logic [1:0] pen, psus, prst;
    logic [3:0] hchg;
    logic power, ocd, sda_o, sda_oe, scl, sda;
    logic [7:0] b0, b1;
    int errors = 0, checked = 0;
    hep_master m_u (.i_clk(i_clk), .i_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda));
    hep_top #(.P_RESET_CYCLES(200)) dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_scl(scl),
        .i_sda(sda), .o_sda(sda_o), .o_sda_oe(sda_oe), .i_mode(mode),
        .i_port_connect(2'h1), .i_port_low_speed(2'h1), .i_overcurrent(oc),
        .i_pkt_done(i_pkt_done), .i_pkt_ep(i_pkt_ep), .i_setup(i_setup),
        .i_setup_ep(i_setup_ep), .o_ep_full(full), .o_ep_stall(stall), .o_ep_toggle(tog),
        .o_port_enable(pen), .o_port_suspend(psus), .o_port_reset(prst), .o_power(power),
        .o_oc_detect(ocd), .o_hub_change(hchg));
    // Clock of 5 ns.
    always #2.5 i_clk = ~i_clk;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            errors++;
            $display("BAD %0t seen %h wanted %h", $time, s, e);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    // One pulse of a packet or SETUP event, then let the flags settle.
    task automatic ev(input logic s, input logic [3:0] ep);
        @(posedge i_clk);
        i_setup <= s;
        i_pkt_done <= ~s;
        i_setup_ep <= ep;
        i_pkt_ep <= ep;
        @(posedge i_clk);
        i_setup <= 1'b0;
        i_pkt_done <= 1'b0;
        repeat (2) @(posedge i_clk);
        #1;
    endtask : ev
    // Command byte to the command address, optional data byte to the data address.
    task automatic cmd(input logic [7:0] c, input logic wd = 1'b0, input logic [7:0] d = 8'h00);
        logic [7:0] r;
        logic n;
        m_u.start();
        m_u.xfer(8'h36, 1'b1, r, n);
        m_u.xfer(c, 1'b1, r, n);
        if (wd) begin
            m_u.start();
            m_u.xfer(8'h34, 1'b1, r, n);
            m_u.xfer(d, 1'b1, r, n);
        end
        chk(n, 1'b0);
        m_u.stop();
        repeat (6) @(posedge i_clk);
        #1;
    endtask : cmd
    initial begin
        #400000;
        errors++;
        tally_and_finish();
    end
    // Main sequence of tests.
    initial begin
        repeat (4) @(posedge i_clk);
        i_reset <= 1'b0;
        repeat (8) @(posedge i_clk);
        #1;
        chk({full, stall, sda_o, sda_oe}, 30'h1);
        ev(1'b0, 4'h2);
        chk(full[2], 1'b1);
        cmd(8'h02);
        cmd(8'hf2);
        chk(full[2], 1'b0);
        cmd(8'h03);
        cmd(8'hfa);
        chk(full[3], 1'b1);
        cmd(8'h43, 1'b1, 8'h01);
        chk(stall[3], 1'b1);
        cmd(8'h43, 1'b1, 8'h00);
        chk({stall[3], full[3], tog[3]}, 3'h0);
        $display("test endpoint done");
        cmd(8'h40, 1'b1, 8'h01);
        ev(1'b1, 4'h0);
        chk({stall[0], full[1], full[0]}, 3'h1);
        cmd(8'h00);
        cmd(8'hf2);
        chk(full[0], 1'b1);
        cmd(8'hf1);
        cmd(8'hf2);
        chk(full[0], 1'b0);
        $display("test setup done");
        cmd(8'he8, 1'b1, 8'h02);
        chk(prst, 2'h1);
        repeat (220) @(posedge i_clk);
        #1;
        chk({prst, pen}, 4'h1);
        m_u.start();
        m_u.xfer(8'h36, 1'b1, b0, b1[0]);
        m_u.xfer(8'he0, 1'b1, b0, b1[0]);
        m_u.start();
        m_u.xfer(8'h35, 1'b1, b0, b1[0]);
        m_u.xfer(8'hff, 1'b0, b0, b1[0]);
        m_u.xfer(8'hff, 1'b1, b1, b1[0]);
        m_u.stop();
        chk(b0, 8'h43);
        chk(b1 & 8'h10, 8'h10);
        $display("test port done");
        cmd(8'he9, 1'b1, 8'h01);
        chk({psus, hchg[3]}, 3'h4);
        cmd(8'he1, 1'b1, 8'h01);
        chk({psus, hchg[3]}, 3'h1);
        cmd(8'he9, 1'b1, 8'h03);
        chk({power, ocd}, 2'h2);
        cmd(8'he8, 1'b1, 8'h03);
        chk({power, ocd}, 2'h3);
        @(posedge i_clk);
        oc <= 2'h2;
        repeat (8) @(posedge i_clk);
        #1;
        chk(hchg[0], 1'b0);
        @(posedge i_clk);
        mode <= 1'b1;
        repeat (8) @(posedge i_clk);
        #1;
        chk(hchg[0], 1'b1);
        cmd(8'he0, 1'b1, 8'h07);
        chk(hchg[0], 1'b0);
        cmd(8'he1, 1'b1, 8'h03);
        chk({power, ocd}, 2'h0);
        cmd(8'hf7, 1'b1, 8'h03);
        chk(hchg[1:0], 2'h3);
        cmd(8'h77, 1'b1, 8'h01);
        chk(stall, 14'h0);
        $display("test hub done");
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire

// ### verilog/hep_link.sv
// Two-wire serial slave that turns link traffic into command and data bytes.
`timescale 1ns/10ps
`default_nettype none
`include "hep_defines.svh"
module hep_link (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_oe,
    hep_if.link bus
);
    import hep_pkg::*;

    hep_link_t s;
    hep_link_t n;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic hit;

    // ------------------------------------------------------------
    // Edge and frame condition detection on synchronised pins
    // ------------------------------------------------------------
    assign rise = s.scl2 & ~s.scl3;
    assign fall = ~s.scl2 & s.scl3;
    assign start = s.scl2 & s.scl3 & s.sda3 & ~s.sda2;
    assign stop = s.scl2 & s.scl3 & ~s.sda3 & s.sda2;
    assign hit = (s.sh[7:1] == `HEP_ADDR_CMD) || (s.sh[7:1] == `HEP_ADDR_DATA);

    // Next state of the byte engine; start and stop override any state.
    always_comb begin
        n = s;
        n.rx_valid = 1'b0;
        n.rd_req = 1'b0;
        n.scl1 = i_scl;
        n.scl2 = s.scl1;
        n.scl3 = s.scl2;
        n.sda1 = i_sda;
        n.sda2 = s.sda1;
        n.sda3 = s.sda2;
        if (start) begin
            n.state = hep_addr;
            n.cnt = 4'h0;
            n.sda_oe = 1'b1;
        end else if (stop) begin
            n.state = hep_idle;
            n.sda_oe = 1'b1;
        end else begin
            case (s.state)
                hep_addr, hep_rx: begin
                    if (rise) begin
                        n.sh = {s.sh[6:0], s.sda2};
                        n.cnt = s.cnt + 4'h1;
                    end else if (fall && s.cnt == 4'h8) begin
                        if (s.state == hep_rx) begin
                            n.rx_valid = 1'b1;
                            n.rx_cmd = s.sel_cmd;
                            n.rx_byte = s.sh;
                            n.sda_oe = 1'b0;
                            n.state = hep_dack;
                        end else if (hit) begin
                            n.rw = s.sh[0];
                            n.sel_cmd = (s.sh[7:1] == `HEP_ADDR_CMD);
                            n.rd_req = s.sh[0];
                            n.sda_oe = 1'b0;
                            n.state = hep_aack;
                        end else begin
                            n.state = hep_idle;
                        end
                    end
                end
                hep_aack: begin
                    if (fall) begin
                        n.cnt = 4'h0;
                        if (s.rw) begin
                            n.sh = bus.tx_byte;
                            n.sda_oe = bus.tx_byte[7];
                            n.state = hep_tx;
                        end else begin
                            n.sda_oe = 1'b1;
                            n.state = hep_rx;
                        end
                    end
                end
                hep_dack: begin
                    if (fall) begin
                        n.sda_oe = 1'b1;
                        n.cnt = 4'h0;
                        n.state = hep_rx;
                    end
                end
                hep_tx: begin
                    if (fall && s.cnt == 4'h7) begin
                        n.sda_oe = 1'b1;
                        n.state = hep_mack;
                    end else if (fall) begin
                        n.sh = {s.sh[6:0], 1'b0};
                        n.cnt = s.cnt + 4'h1;
                        n.sda_oe = s.sh[6];
                    end
                end
                hep_mack: begin
                    if (rise && !s.sda2) begin
                        n.rd_req = 1'b1;
                        n.state = hep_aack;
                    end else if (rise) begin
                        n.state = hep_idle;
                    end
                end
                default: n.state = hep_idle;
            endcase
        end
    end

    // State register; the data line is released during reset.
    // The pin copies rest at the idle high level, so no false edge follows reset.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            s <= '0;
            s.sda_oe <= 1'b1;
            s.scl1 <= 1'b1;
            s.scl2 <= 1'b1;
            s.scl3 <= 1'b1;
            s.sda1 <= 1'b1;
            s.sda2 <= 1'b1;
            s.sda3 <= 1'b1;
        end else begin
            s <= n;
        end
    end

    // Outputs toward the pin and the core.
    assign o_sda_oe = s.sda_oe;
    assign bus.rx_valid = s.rx_valid;
    assign bus.rx_cmd = s.rx_cmd;
    assign bus.rx_byte = s.rx_byte;
    assign bus.rd_req = s.rd_req;

    // A matched address is acknowledged by pulling the line low.
    a_addr_ack: assert property (@(posedge i_clk) disable iff (i_reset)
        (s.state == hep_addr && fall && s.cnt == 4'h8 && hit && !start && !stop)
        |=> !s.sda_oe && s.state == hep_aack)
        else $error("matched address not acknowledged");
    // Each received data byte appears once, with the shifted value.
    a_rx_byte: assert property (@(posedge i_clk) disable iff (i_reset)
        (s.state == hep_rx && fall && s.cnt == 4'h8 && !start && !stop)
        |=> s.rx_valid && s.rx_byte == $past(s.sh) ##1 !s.rx_valid)
        else $error("received byte not delivered once");
endmodule : hep_link
`default_nettype wire

// ### verilog/hep_top.sv
// Command core of the hub endpoint and port command unit.
//
// Function
// - Received packet sets full; full buffer NAKs.
// - Clear buffer command frees selected buffer.
// - Validate command marks selected IN buffer full.
// - Stall command; zero reinitialises the endpoint.
// - SETUP token unstalls a control endpoint.
// - Unstall flushes buffer, toggle back to DATA0.
// - SETUP flushes IN, blocks clear and validate.
// - Acknowledge setup command lifts the selected buffer's block.
// - Port feature clear/set codes take one byte.
// - Feature selector decode, change clears four-seven.
// - Mode zero: power, overcurrent change hub wide.
// - Mode one: overcurrent per port, one switch.
// - Set power twice; clear drops power, detection.
// - Status read returns status then change byte.
// - Status byte reports the seven port conditions.
// - Reset bit high during downstream reset, 10 ms.
// - Low speed needs connect; change bits on change.
// - Local change byte merged into hub report.
`timescale 1ns/10ps
`default_nettype none
`include "hep_defines.svh"
module hep_top #(
    parameter int unsigned P_RESET_CYCLES = `HEP_PRST_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe,
    input wire logic i_mode,
    input wire logic [1:0] i_port_connect,
    input wire logic [1:0] i_port_low_speed,
    input wire logic [1:0] i_overcurrent,
    input wire logic i_pkt_done,
    input wire logic [3:0] i_pkt_ep,
    input wire logic i_setup,
    input wire logic [3:0] i_setup_ep,
    output logic [`HEP_EP_NUM-1:0] o_ep_full,
    output logic [`HEP_EP_NUM-1:0] o_ep_stall,
    output logic [`HEP_EP_NUM-1:0] o_ep_toggle,
    output logic [1:0] o_port_enable,
    output logic [1:0] o_port_suspend,
    output logic [1:0] o_port_reset,
    output logic o_power,
    output logic o_oc_detect,
    output logic [3:0] o_hub_change
);
    import hep_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // True when a code lies inside an inclusive range.
    function automatic logic hep_in(input logic [7:0] b, input logic [7:0] lo,
        input logic [7:0] hi);
        hep_in = (b >= lo) && (b <= hi);
    endfunction : hep_in

    // Builds the condition byte of one downstream port.
    function automatic logic [7:0] hep_status(input hep_core_t c, input logic p);
        hep_status = 8'h00;
        hep_status[`HEP_ST_CONN] = c.conn[p];
        hep_status[`HEP_ST_ENABLE] = c.en[p];
        hep_status[`HEP_ST_SUSPEND] = c.susp[p];
        hep_status[`HEP_ST_OVERCUR] = c.oc_st[p];
        hep_status[`HEP_ST_RESET] = c.rst[p];
        hep_status[`HEP_ST_POWER] = c.power;
        hep_status[`HEP_ST_LOWSPEED] = c.ls[p] & c.conn[p];
    endfunction : hep_status

    // Builds the change byte of one downstream port.
    function automatic logic [7:0] hep_change(input hep_core_t c, input logic p);
        hep_change = 8'h00;
        hep_change[`HEP_ST_CONN] = c.c_conn[p];
        hep_change[`HEP_ST_ENABLE] = c.c_en[p];
        hep_change[`HEP_ST_SUSPEND] = c.c_susp[p];
        hep_change[`HEP_ST_OVERCUR] = c.c_oc;
        hep_change[`HEP_ST_RESET] = c.c_rst[p];
    endfunction : hep_change

    // ------------------------------------------------------------
    // Link slave
    // ------------------------------------------------------------
    hep_if bus();
    hep_core_t s;
    hep_core_t n;
    logic [1:0] oc_in;
    logic [3:0] ev_out;
    logic [3:0] ev_in;
    logic p;
    logic [2:0] ft;

    hep_link u_link (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_scl(i_scl),
        .i_sda(i_sda),
        .o_sda_oe(o_sda_oe),
        .bus(bus)
    );

    // Overcurrent source and SETUP endpoint pair.
    assign oc_in = s.mode2 ? s.oc2 : {2{s.oc2[0]}};
    assign ev_out = {i_setup_ep[3:1], 1'b0};
    assign ev_in = {i_setup_ep[3:1], 1'b1};
    assign p = s.cmd[0];
    assign ft = bus.rx_byte[2:0];

    // ------------------------------------------------------------
    // Command decode and endpoint and port state
    // ------------------------------------------------------------
    // Commands are applied first so that hardware events set later win.
    always_comb begin
        n = s;
        n.sda_o = 1'b0;
        n.con1 = i_port_connect;
        n.con2 = s.con1;
        n.ls1 = i_port_low_speed;
        n.ls2 = s.ls1;
        n.oc1 = i_overcurrent;
        n.oc2 = s.oc1;
        n.mode1 = i_mode;
        n.mode2 = s.mode1;
        if (bus.rx_valid && bus.rx_cmd) begin
            n.cmd = bus.rx_byte;
            n.wr_done = 1'b0;
            n.rd_idx = 2'h0;
            if (hep_in(bus.rx_byte, `HEP_CMD_SEL_LO, `HEP_CMD_SEL_HI)) begin
                n.sel = bus.rx_byte[3:0];
            end else if (bus.rx_byte == `HEP_CMD_CLR_BUF && !s.blk[s.sel]) begin
                n.full[s.sel] = 1'b0;
            end else if (bus.rx_byte == `HEP_CMD_VALIDATE && !s.blk[s.sel] && s.sel[0]) begin
                n.full[s.sel] = 1'b1;
            end else if (bus.rx_byte == `HEP_CMD_ACK_SETUP) begin
                n.blk[s.sel] = 1'b0;
            end
        end else if (bus.rx_valid && !s.wr_done) begin
            n.wr_done = 1'b1;
            if (hep_in(s.cmd, `HEP_CMD_STALL_LO, `HEP_CMD_STALL_HI)) begin
                n.stall[s.cmd[3:0]] = bus.rx_byte[0];
                if (!bus.rx_byte[0]) begin
                    n.full[s.cmd[3:0]] = 1'b0;
                    n.tog[s.cmd[3:0]] = 1'b0;
                end
            end else if (s.cmd == `HEP_CMD_LOCAL_CHG) begin
                n.local_chg = bus.rx_byte[1:0];
            end else if ((s.cmd == `HEP_CMD_CLR_P0 || s.cmd == `HEP_CMD_CLR_P1 ||
                s.cmd == `HEP_CMD_SET_P0 || s.cmd == `HEP_CMD_SET_P1) &&
                bus.rx_byte[7:3] == 5'h00) begin
                case (ft)
                    `HEP_FT_ENABLE: n.en[p] = s.cmd[3];
                    `HEP_FT_SUSPEND: begin
                        if (s.cmd[3]) begin
                            n.susp[p] = 1'b1;
                        end else if (s.susp[p]) begin
                            n.susp[p] = 1'b0;
                            n.c_susp[p] = 1'b1;
                        end
                    end
                    `HEP_FT_RESTART: begin
                        if (s.cmd[3]) begin
                            n.rst[p] = 1'b1;
                            n.rtim[p] = `HEP_TIMER_W'(P_RESET_CYCLES);
                        end else begin
                            n.c_rst[p] = 1'b0;
                        end
                    end
                    `HEP_FT_POWER: begin
                        // The switch is ganged, so the port number plays no part.
                        if (s.cmd[3] && !s.power) begin
                            n.power = 1'b1;
                        end else if (s.cmd[3]) begin
                            n.oc_det = 1'b1;
                        end else begin
                            n.power = 1'b0;
                            n.oc_det = 1'b0;
                        end
                    end
                    `HEP_FT_C_CONN: if (!s.cmd[3]) n.c_conn[p] = 1'b0;
                    `HEP_FT_C_ENABLE: if (!s.cmd[3]) n.c_en[p] = 1'b0;
                    `HEP_FT_C_SUSPEND: if (!s.cmd[3]) n.c_susp[p] = 1'b0;
                    default: if (!s.cmd[3]) n.c_oc = 1'b0;
                endcase
            end
        end
        // Status reads: condition byte, change byte, then zeros.
        if (bus.rd_req) begin
            n.tx_byte = 8'h00;
            if (s.cmd == `HEP_CMD_CLR_P0 || s.cmd == `HEP_CMD_CLR_P1) begin
                if (s.rd_idx == 2'h0) begin
                    n.tx_byte = hep_status(s, p);
                end else if (s.rd_idx == 2'h1) begin
                    n.tx_byte = hep_change(s, p);
                end
            end
            if (s.rd_idx != 2'h2) begin
                n.rd_idx = s.rd_idx + 2'h1;
            end
        end
        // Port condition tracking and downstream reset timing.
        for (int i = 0; i < 2; i++) begin
            n.conn[i] = s.con2[i];
            n.ls[i] = s.ls2[i];
            n.oc_st[i] = oc_in[i] & s.oc_det;
            if (s.con2[i] != s.conn[i]) begin
                n.c_conn[i] = 1'b1;
            end
            if (!s.con2[i] && s.conn[i] && s.en[i]) begin
                n.en[i] = 1'b0;
                n.c_en[i] = 1'b1;
            end
            if (s.rst[i] && s.rtim[i] <= `HEP_TIMER_W'(1)) begin
                n.rst[i] = 1'b0;
                n.en[i] = 1'b1;
                n.c_rst[i] = 1'b1;
            end else if (s.rst[i]) begin
                n.rtim[i] = s.rtim[i] - `HEP_TIMER_W'(1);
            end
        end
        // Overcurrent change is one hub-wide flag in either mode.
        if ((oc_in & {2{s.oc_det}}) != s.oc_st) begin
            n.c_oc = 1'b1;
        end
        // A completed packet fills its buffer and flips its toggle.
        if (i_pkt_done && i_pkt_ep < 4'(`HEP_EP_NUM)) begin
            n.full[i_pkt_ep] = 1'b1;
            n.tog[i_pkt_ep] = ~s.tog[i_pkt_ep];
        end
        // A SETUP token reinitialises the pair and blocks buffer commands.
        if (i_setup && i_setup_ep < 4'(`HEP_EP_NUM)) begin
            n.stall[ev_out] = 1'b0;
            n.stall[ev_in] = 1'b0;
            n.tog[ev_out] = 1'b0;
            n.tog[ev_in] = 1'b0;
            n.full[ev_in] = 1'b0;
            n.full[ev_out] = 1'b1;
            n.blk[ev_out] = 1'b1;
            n.blk[ev_in] = 1'b1;
        end
        n.hub_chg = {|hep_change(s, 1'b1), |hep_change(s, 1'b0),
            s.local_chg[1], s.local_chg[0] | s.c_oc};
    end

    // State register.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign bus.tx_byte = s.tx_byte;
    assign o_sda = s.sda_o;
    assign o_ep_full = s.full;
    assign o_ep_stall = s.stall;
    assign o_ep_toggle = s.tog;
    assign o_port_enable = s.en;
    assign o_port_suspend = s.susp;
    assign o_port_reset = s.rst;
    assign o_power = s.power;
    assign o_oc_detect = s.oc_det;
    assign o_hub_change = s.hub_chg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic a_ep_wr;
    logic a_cmd;
    assign a_cmd = bus.rx_valid && bus.rx_cmd && !i_setup && !i_pkt_done;
    assign a_ep_wr = bus.rx_valid && !bus.rx_cmd && !s.wr_done && !i_setup &&
        !i_pkt_done && hep_in(s.cmd, `HEP_CMD_STALL_LO, `HEP_CMD_STALL_HI);

    a_full_on_packet: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_pkt_done && i_pkt_ep < 4'(`HEP_EP_NUM)) |=> o_ep_full[$past(i_pkt_ep)])
        else $error("packet did not fill its buffer");
    a_clear_buffer: assert property (@(posedge i_clk) disable iff (i_reset)
        (a_cmd && bus.rx_byte == `HEP_CMD_CLR_BUF && !s.blk[s.sel])
        |=> !s.full[$past(s.sel)])
        else $error("clear buffer left buffer full");
    a_validate_in: assert property (@(posedge i_clk) disable iff (i_reset)
        (a_cmd && bus.rx_byte == `HEP_CMD_VALIDATE && s.sel[0])
        |=> s.full[$past(s.sel)] == !$past(s.blk[s.sel]) || $past(s.full[s.sel]))
        else $error("validate did not follow the block state");
    a_stall_zero: assert property (@(posedge i_clk) disable iff (i_reset)
        (a_ep_wr && !bus.rx_byte[0]) |=> !s.stall[$past(s.cmd[3:0])] &&
        !s.full[$past(s.cmd[3:0])] && !s.tog[$past(s.cmd[3:0])])
        else $error("zero stall write did not reinitialise");
    a_setup_unstall: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_setup && i_setup_ep < 4'(`HEP_EP_NUM) && !i_pkt_done)
        |=> !s.stall[$past(ev_out)] && !s.stall[$past(ev_in)] && !s.tog[$past(ev_in)])
        else $error("setup did not unstall the pair");
    a_setup_block: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_setup && i_setup_ep < 4'(`HEP_EP_NUM) && !i_pkt_done)
        |=> s.blk[$past(ev_in)] && s.blk[$past(ev_out)] && !s.full[$past(ev_in)])
        else $error("setup did not flush and block");
    a_reset_done: assert property (@(posedge i_clk) disable iff (i_reset)
        $fell(s.rst[0]) |-> s.c_rst[0] && s.en[0])
        else $error("port reset ended without change flag");
    a_status_read: assert property (@(posedge i_clk) disable iff (i_reset)
        (bus.rd_req && s.cmd == `HEP_CMD_CLR_P0 && s.rd_idx == 2'h0)
        |=> s.tx_byte == hep_status($past(s), 1'b0) ##0 s.rd_idx == 2'h1)
        else $error("first status read wrong");
endmodule : hep_top
`default_nettype wire
